// ---- range_clamp_defines.svh ----
/*
 * Register offsets, field positions, reset values and output codes of the
 * measurement result range clamp.
 * Assumes inclusion by bare name from the package and the design module.
 */
`ifndef RANGE_CLAMP_DEFINES_SVH
`define RANGE_CLAMP_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define RC_OFS_CTRL 8'h00
`define RC_OFS_ABS_LOW 8'h04
`define RC_OFS_NOM_LOW 8'h08
`define RC_OFS_NOM_HIGH 8'h0c
`define RC_OFS_ABS_HIGH 8'h10
`define RC_OFS_RESULT 8'h14
`define RC_OFS_IRQ_STATUS 8'h18
`define RC_OFS_IRQ_MASK 8'h1c

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define RC_CTRL_COMP_BIT 0
`define RC_RST_ABS_LOW 10'h000
`define RC_RST_NOM_LOW 10'h000
`define RC_RST_NOM_HIGH 10'h3ff
`define RC_RST_ABS_HIGH 10'h3ff
`define RC_IRQ_ERROR_BIT 0
`define RC_IRQ_UNDER_BIT 1
`define RC_IRQ_OVER_BIT 2
`define RC_IRQ_WIDTH 3

// ----------------------------------------------------------------
// Output codes
// ----------------------------------------------------------------
`define RC_CODE_ERROR 9'h000
`define RC_CODE_MIN 9'h001
`define RC_CODE_MAX 9'h1fe
`define RC_AXI_OKAY 2'b00
`define RC_AXI_SLVERR 2'b10

`endif

// ---- range_clamp_pkg.sv ----
/*
 * Types shared by the range clamp design.
 * Assumes range_clamp_defines.svh is on the include path.
 */
package range_clamp_pkg;
	`include "range_clamp_defines.svh"

	typedef struct packed {
		logic [9:0] abs_low_limit;
		logic [9:0] nominal_low_level;
		logic [9:0] nominal_high_level;
		logic [9:0] abs_high_limit;
	} levels_t;

	typedef struct packed {
		logic valid;
		logic [9:0] code;
		logic error;
		logic underflow;
		logic overflow;
	} result_t;
endpackage

// ---- measurement_result_range_clamp.sv ----
/*
 * Range check and saturation of one measured parameter, with an AXI4-Lite
 * register slave holding the four levels, the mode and interrupt state.
 * Assumes the converter and the compensation path sit on clk_i.
 */
`timescale 1ns/100ps
`include "range_clamp_defines.svh"

module measurement_result_range_clamp
	import range_clamp_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Measurement in
	input wire logic sample_valid_i,
	input wire logic [9:0] raw_code_i,
	input wire logic signed [11:0] comp_value_i,
	// Measurement out
	output result_t result_o,
	output logic irq_o,
	// AXI4-Lite
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	levels_t levels, next_levels;
	logic comp_mode, next_comp_mode;
	logic [`RC_IRQ_WIDTH-1:0] irq_status, next_irq_status;
	logic [`RC_IRQ_WIDTH-1:0] irq_mask, next_irq_mask;
	result_t result, next_result;

	logic aw_held, next_aw_held;
	logic w_held, next_w_held;
	logic [7:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic [3:0] w_strb, next_w_strb;
	logic bvalid, next_bvalid;
	logic [1:0] bresp, next_bresp;
	logic rvalid, next_rvalid;
	logic [1:0] rresp, next_rresp;
	logic [31:0] rdata, next_rdata;

	logic wr_fire;
	logic wr_hit;
	logic [`RC_IRQ_WIDTH-1:0] events;

	assign s_axi_awready = !aw_held && !bvalid;
	assign s_axi_wready = !w_held && !bvalid;
	assign s_axi_arready = !rvalid;
	assign s_axi_bvalid = bvalid;
	assign s_axi_bresp = bresp;
	assign s_axi_rvalid = rvalid;
	assign s_axi_rresp = rresp;
	assign s_axi_rdata = rdata;
	assign result_o = result;
	assign irq_o = |(irq_status & irq_mask);
	assign wr_fire = aw_held && w_held && !bvalid;

	// ----------------------------------------------------------------
	// Classification and saturation
	// ----------------------------------------------------------------
	always_comb begin
		next_result = result;
		next_result.valid = 1'b0;
		if (sample_valid_i) begin
			next_result.valid = 1'b1;
			next_result.error = 1'b0;
			next_result.underflow = 1'b0;
			next_result.overflow = 1'b0;
			if (raw_code_i < levels.abs_low_limit || raw_code_i > levels.abs_high_limit) begin
				next_result.error = 1'b1;
				next_result.code = 10'({`RC_CODE_ERROR});
			end else if (!comp_mode) begin
				next_result.code = raw_code_i;
			end else if (comp_value_i < 12'(signed'({1'b0, `RC_CODE_MIN}))) begin
				next_result.underflow = 1'b1;
				next_result.code = 10'({`RC_CODE_MIN});
			end else if (comp_value_i > 12'(signed'({1'b0, `RC_CODE_MAX}))) begin
				next_result.overflow = 1'b1;
				next_result.code = 10'({`RC_CODE_MAX});
			end else begin
				next_result.code = comp_value_i[9:0];
			end
		end
	end

	assign events = {result.valid && result.overflow, result.valid && result.underflow,
		result.valid && result.error};

	// ----------------------------------------------------------------
	// Register file and bus slave
	// ----------------------------------------------------------------
	always_comb begin
		next_levels = levels;
		next_comp_mode = comp_mode;
		next_irq_mask = irq_mask;
		next_irq_status = irq_status;
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_rvalid = rvalid;
		next_rresp = rresp;
		next_rdata = rdata;
		wr_hit = 1'b1;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (wr_fire) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			// Limits are 10 bits wide, so only lanes 0 and 1 matter
			if (aw_addr == `RC_OFS_CTRL) begin
				if (w_strb[0]) next_comp_mode = w_data[`RC_CTRL_COMP_BIT];
			end else if (aw_addr == `RC_OFS_ABS_LOW) begin
				if (w_strb[0]) next_levels.abs_low_limit[7:0] = w_data[7:0];
				if (w_strb[1]) next_levels.abs_low_limit[9:8] = w_data[9:8];
			end else if (aw_addr == `RC_OFS_NOM_LOW) begin
				if (w_strb[0]) next_levels.nominal_low_level[7:0] = w_data[7:0];
				if (w_strb[1]) next_levels.nominal_low_level[9:8] = w_data[9:8];
			end else if (aw_addr == `RC_OFS_NOM_HIGH) begin
				if (w_strb[0]) next_levels.nominal_high_level[7:0] = w_data[7:0];
				if (w_strb[1]) next_levels.nominal_high_level[9:8] = w_data[9:8];
			end else if (aw_addr == `RC_OFS_ABS_HIGH) begin
				if (w_strb[0]) next_levels.abs_high_limit[7:0] = w_data[7:0];
				if (w_strb[1]) next_levels.abs_high_limit[9:8] = w_data[9:8];
			end else if (aw_addr == `RC_OFS_IRQ_STATUS) begin
				if (w_strb[0]) next_irq_status = irq_status & ~w_data[`RC_IRQ_WIDTH-1:0];
			end else if (aw_addr == `RC_OFS_IRQ_MASK) begin
				if (w_strb[0]) next_irq_mask = w_data[`RC_IRQ_WIDTH-1:0];
			end else if (aw_addr != `RC_OFS_RESULT) begin
				wr_hit = 1'b0;
			end
			next_bresp = wr_hit ? `RC_AXI_OKAY : `RC_AXI_SLVERR;
		end
		// Set after clear so a same-cycle event is never lost
		next_irq_status = next_irq_status | events;
		if (bvalid && s_axi_bready) next_bvalid = 1'b0;
		if (rvalid && s_axi_rready) next_rvalid = 1'b0;
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp = `RC_AXI_OKAY;
			next_rdata = 32'h0000_0000;
			if (s_axi_araddr == `RC_OFS_CTRL) begin
				next_rdata[`RC_CTRL_COMP_BIT] = comp_mode;
			end else if (s_axi_araddr == `RC_OFS_ABS_LOW) begin
				next_rdata[9:0] = levels.abs_low_limit;
			end else if (s_axi_araddr == `RC_OFS_NOM_LOW) begin
				next_rdata[9:0] = levels.nominal_low_level;
			end else if (s_axi_araddr == `RC_OFS_NOM_HIGH) begin
				next_rdata[9:0] = levels.nominal_high_level;
			end else if (s_axi_araddr == `RC_OFS_ABS_HIGH) begin
				next_rdata[9:0] = levels.abs_high_limit;
			end else if (s_axi_araddr == `RC_OFS_RESULT) begin
				next_rdata[9:0] = result.code;
				next_rdata[12:10] = {result.overflow, result.underflow, result.error};
			end else if (s_axi_araddr == `RC_OFS_IRQ_STATUS) begin
				next_rdata[`RC_IRQ_WIDTH-1:0] = irq_status;
			end else if (s_axi_araddr == `RC_OFS_IRQ_MASK) begin
				next_rdata[`RC_IRQ_WIDTH-1:0] = irq_mask;
			end else begin
				next_rresp = `RC_AXI_SLVERR;
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			levels <= {`RC_RST_ABS_LOW, `RC_RST_NOM_LOW, `RC_RST_NOM_HIGH, `RC_RST_ABS_HIGH};
			comp_mode <= 1'b0;
			irq_status <= '0;
			irq_mask <= '0;
			result <= '0;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= 2'b00;
			rvalid <= 1'b0;
			rresp <= 2'b00;
			rdata <= 32'h0000_0000;
		end else begin
			levels <= next_levels;
			comp_mode <= next_comp_mode;
			irq_status <= next_irq_status;
			irq_mask <= next_irq_mask;
			result <= next_result;
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rresp <= next_rresp;
			rdata <= next_rdata;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_out_of_range_zero;
		@(posedge clk_i) disable iff (rst_i)
		sample_valid_i && (raw_code_i < levels.abs_low_limit || raw_code_i > levels.abs_high_limit)
		|=> result.valid && result.error && result.code == 10'h000;
	endproperty
	a_out_of_range_zero: assert property (p_out_of_range_zero) else $error("range error not zero");

	property p_comp_span;
		@(posedge clk_i) disable iff (rst_i)
		result.valid && !result.error && $past(comp_mode)
		|-> result.code >= 10'h001 && result.code <= 10'h1fe;
	endproperty
	a_comp_span: assert property (p_comp_span) else $error("compensated code out of span");

	property p_underflow;
		@(posedge clk_i) disable iff (rst_i)
		sample_valid_i && comp_mode && raw_code_i >= levels.abs_low_limit
		&& raw_code_i <= levels.abs_high_limit && comp_value_i < 12'sd1
		|=> result.underflow && result.code == 10'h001;
	endproperty
	a_underflow: assert property (p_underflow) else $error("underflow not forced to 1");

	property p_overflow;
		@(posedge clk_i) disable iff (rst_i)
		sample_valid_i && comp_mode && raw_code_i >= levels.abs_low_limit
		&& raw_code_i <= levels.abs_high_limit && comp_value_i > 12'sd510
		|=> result.overflow && result.code == 10'h1fe;
	endproperty
	a_overflow: assert property (p_overflow) else $error("overflow not forced to 510");

	property p_in_span_kept;
		@(posedge clk_i) disable iff (rst_i)
		sample_valid_i && comp_mode && raw_code_i >= levels.abs_low_limit
		&& raw_code_i <= levels.abs_high_limit && comp_value_i >= 12'sd1 && comp_value_i <= 12'sd510
		|=> result.code == $past(comp_value_i[9:0]) && !result.underflow && !result.overflow;
	endproperty
	a_in_span_kept: assert property (p_in_span_kept) else $error("in-span value altered");

	property p_raw_pass;
		@(posedge clk_i) disable iff (rst_i)
		sample_valid_i && !comp_mode && raw_code_i >= levels.abs_low_limit
		&& raw_code_i <= levels.abs_high_limit
		|=> result.code == $past(raw_code_i) && !result.error;
	endproperty
	a_raw_pass: assert property (p_raw_pass) else $error("raw code not passed");

	property p_valid_timing;
		@(posedge clk_i) disable iff (rst_i)
		sample_valid_i |=> result.valid ##1 (result.valid == $past(sample_valid_i));
	endproperty
	a_valid_timing: assert property (p_valid_timing) else $error("valid not one cycle late");

	property p_error_irq;
		@(posedge clk_i) disable iff (rst_i)
		result.valid && result.error |=> irq_status[`RC_IRQ_ERROR_BIT];
	endproperty
	a_error_irq: assert property (p_error_irq) else $error("error event not latched");

endmodule

// ---- conv_source_model.sv ----
/*
 * Model of the converter and compensation path feeding the range clamp.
 * Assumes the bench commands one sample per req_i cycle on clk_i.
 */
`timescale 1ns/100ps
module conv_source_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Bench command
	input wire logic req_i,
	input wire logic [9:0] raw_i,
	input wire logic signed [11:0] comp_i,
	// Toward the clamp
	output logic sample_valid_o,
	output logic [9:0] raw_code_o,
	output logic signed [11:0] comp_value_o
);
	// Buses toggle between samples so stale data never looks held
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sample_valid_o <= 1'b0;
			raw_code_o <= 10'h000;
			comp_value_o <= 12'sh000;
		end else if (req_i) begin
			sample_valid_o <= 1'b1;
			raw_code_o <= raw_i;
			comp_value_o <= comp_i;
		end else begin
			sample_valid_o <= 1'b0;
			raw_code_o <= ~raw_code_o;
			comp_value_o <= ~comp_value_o;
		end
	end
endmodule

// ---- tb_top.sv ----
/*
 * Bench for the range clamp: register and sample sequences with expected values.
 * Assumes defines, package, design and source model are compiled first.
 */
`timescale 1ns/100ps
`include "range_clamp_defines.svh"
module tb_top
	import range_clamp_pkg::*;
;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic req = 1'b0;
	logic [9:0] raw = 10'h000;
	logic signed [11:0] comp = 12'sh000;
	logic sample_valid;
	logic [9:0] raw_code;
	logic signed [11:0] comp_value;
	result_t result;
	logic irq;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic [3:0] strb_sel = 4'hf;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, resp;
	logic [31:0] rdata, rd;
	int n_fail = 0;
	int n_tests = 0;
	logic [7:0] ofs[7] = '{`RC_OFS_CTRL, `RC_OFS_ABS_LOW, `RC_OFS_NOM_LOW, `RC_OFS_NOM_HIGH,
		`RC_OFS_ABS_HIGH, `RC_OFS_IRQ_STATUS, `RC_OFS_IRQ_MASK};
	logic [31:0] rstv[7] = '{32'h0, 32'h0, 32'h0, 32'h3ff, 32'h3ff, 32'h0, 32'h0};
	logic [31:0] lvl[4] = '{32'h010, 32'h040, 32'h380, 32'h3f0};
	logic [9:0] raws[12] = '{10'h200, 10'h010, 10'h3f0, 10'h00f, 10'h3f1, 10'h100, 10'h100,
		10'h100, 10'h100, 10'h100, 10'h100, 10'h3ff};
	logic [11:0] comps[12] = '{12'h0, 12'h0, 12'h0, 12'h0, 12'h0, 12'h0, 12'hffb, 12'h001,
		12'h1fe, 12'h1ff, 12'h7ff, 12'h005};
	logic [9:0] codes[12] = '{10'h200, 10'h010, 10'h3f0, 10'h0, 10'h0, 10'h1, 10'h1, 10'h1,
		10'h1fe, 10'h1fe, 10'h1fe, 10'h0};
	logic [2:0] flags[12] = '{3'h0, 3'h0, 3'h0, 3'h4, 3'h4, 3'h2, 3'h2, 3'h0, 3'h0, 3'h1,
		3'h1, 3'h4};

	initial begin
		forever #2.5 clk_i = ~clk_i;
	end

	conv_source_model conv_source_model_inst (.clk_i(clk_i), .rst_i(rst_i), .req_i(req),
		.raw_i(raw), .comp_i(comp), .sample_valid_o(sample_valid), .raw_code_o(raw_code),
		.comp_value_o(comp_value));

	measurement_result_range_clamp measurement_result_range_clamp_inst (.clk_i(clk_i),
		.rst_i(rst_i), .sample_valid_i(sample_valid), .raw_code_i(raw_code),
		.comp_value_i(comp_value), .result_o(result), .irq_o(irq), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic test_done();
		$display("Checks %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk_i);
		awaddr <= a;
		wdata <= d;
		wstrb <= strb_sel;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge clk_i);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge clk_i);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
		end
	endtask

	// Result must appear with its flags in the valid cycle
	task automatic sample(input int i);
		int t;
		@(posedge clk_i);
		req <= 1'b1;
		raw <= raws[i];
		comp <= comps[i];
		@(posedge clk_i);
		req <= 1'b0;
		for (t = 0; t < 8 && result.valid !== 1'b1; t++) begin
			@(posedge clk_i);
			#1;
		end
		chk("valid", 32'(result.valid), 32'h1);
		chk("code", 32'(result.code), 32'(codes[i]));
		chk("flags", 32'({result.error, result.underflow, result.overflow}), 32'(flags[i]));
	endtask

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		foreach (ofs[i]) begin
			rd_reg(ofs[i], rd, resp);
			chk("reset value", rd, rstv[i]);
			chk("reset rresp", 32'(resp), 32'(`RC_AXI_OKAY));
		end
		foreach (lvl[i]) begin
			wr_reg(ofs[i + 1], lvl[i], resp);
			chk("level bresp", 32'(resp), 32'(`RC_AXI_OKAY));
			rd_reg(ofs[i + 1], rd, resp);
			chk("level", rd, lvl[i]);
		end
		foreach (raws[i]) begin
			if (i == 5) wr_reg(`RC_OFS_CTRL, 32'h1, resp);
			sample(i);
		end
		rd_reg(`RC_OFS_IRQ_STATUS, rd, resp);
		chk("status", rd, 32'h7);
		chk("irq masked", 32'(irq), 32'h0);
		wr_reg(`RC_OFS_IRQ_MASK, 32'h1, resp);
		chk("irq error", 32'(irq), 32'h1);
		wr_reg(`RC_OFS_IRQ_STATUS, 32'h1, resp);
		rd_reg(`RC_OFS_IRQ_STATUS, rd, resp);
		chk("status w1c", rd, 32'h6);
		chk("irq cleared", 32'(irq), 32'h0);
		rd_reg(8'h20, rd, resp);
		chk("unmapped rresp", 32'(resp), 32'(`RC_AXI_SLVERR));
		chk("unmapped rdata", rd, 32'h0);
		wr_reg(8'h20, 32'h1, resp);
		chk("unmapped bresp", 32'(resp), 32'(`RC_AXI_SLVERR));
		rd_reg(`RC_OFS_CTRL, rd, resp);
		chk("ctrl", rd, 32'h1);
		// Last sample was out of range: code 0 with the error bit
		rd_reg(`RC_OFS_RESULT, rd, resp);
		chk("result reg", rd, 32'h400);
		wr_reg(`RC_OFS_RESULT, 32'h0, resp);
		chk("result wr bresp", 32'(resp), 32'(`RC_AXI_OKAY));
		rd_reg(`RC_OFS_RESULT, rd, resp);
		chk("result read only", rd, 32'h400);
		// Lane 1 held back, so bits 9:8 keep their old value
		strb_sel = 4'h1;
		wr_reg(`RC_OFS_NOM_LOW, 32'h3ff, resp);
		strb_sel = 4'hf;
		rd_reg(`RC_OFS_NOM_LOW, rd, resp);
		chk("lane 0 only", rd, 32'h0ff);
		test_done();
	end

	// Generous bound: the sequence needs well under a thousand cycles
	initial begin
		#20000;
		n_fail++;
		test_done();
	end
endmodule
